// ### rtl/uart_rx_cfg.svh
`ifndef UART_RX_CFG_SVH
`define UART_RX_CFG_SVH

// ********
// register byte offsets
// ********
`define RX_CTRL_OFS        12'h000
`define RX_BAUD_OFS        12'h004
`define RX_STATUS_OFS      12'h008
`define RX_DATA_OFS        12'h00C

// ********
// control register fields
// ********
`define RX_CTRL_EN_BIT     0
`define RX_CTRL_DS_BIT     1
`define RX_CTRL_PEN_BIT    2
`define RX_CTRL_PODD_BIT   3
`define RX_CTRL_CSZ_LSB    4
`define RX_CTRL_CSZ_MSB    7
`define RX_CTRL_RESET      32'h0000_0080

// ********
// status register fields
// ********
`define RX_STAT_RXC_BIT    0
`define RX_STAT_FE_BIT     1
`define RX_STAT_DOR_BIT    2
`define RX_STAT_PE_BIT     3
`define RX_STAT_BUSY_BIT   4

// ********
// baud divisor and sampling counts
// ********
`define RX_BAUD_W          12
`define RX_BAUD_RESET      12'h000
`define RX_SPB_NORMAL      5'h10
`define RX_SPB_DOUBLE      5'h08
`define RX_VOTE_NORMAL     5'h08
`define RX_VOTE_DOUBLE     5'h04
`define RX_CSZ_MIN         4'h5
`define RX_CSZ_MAX         4'h9
`define RX_CSZ_DEFAULT     4'h8

// ********
// bus answers
// ********
`define AXI_RESP_OKAY      2'b00
`define AXI_RESP_SLVERR    2'b10

`endif

// ### rtl/uart_rx_pkg.sv
package uart_rx_pkg;

  // ****************************************************************
  // receiver sequencing states
  // ****************************************************************
  typedef enum logic [2:0] {
    st_idle,   // waiting for a falling edge
    st_start,  // checking and timing the start bit
    st_bits,   // data and parity bits
    st_stop,   // first stop bit
    st_tail    // double speed hold-off after stop vote
  } rx_state_e;

  // ****************************************************************
  // one stored frame with its status
  // ****************************************************************
  typedef struct packed {
    logic       frame_err;   // stop bit voted low
    logic       overrun;     // frame(s) lost before this one
    logic       parity_err;  // parity mismatch
    logic [8:0] data;        // data bits, lsb first on the wire
  } rx_entry_s;

endpackage : uart_rx_pkg

// ### rtl/rx_line_sync.sv
`timescale 1ns/1ps

// ****************************************************************
// three stage pin synchroniser with agreement filter
// ****************************************************************
module rx_line_sync (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // raw pin and clean level
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1;  // metastability catcher, read only by s2
  logic s2;  // second stage
  logic s3;  // third stage

  // shift chain; idle line is high, so reset to one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_out <= 1'b1;
    end else if (s2 == s3) begin
      level_out <= s3;
    end
  end

endmodule : rx_line_sync

// ### rtl/uart_rx_recovery.sv
`timescale 1ns/1ps
`include "uart_rx_cfg.svh"

// Notes on behaviour
// - sample sixteen per bit, eight double speed
// - double speed when select bit is one
// - falling edge on idle line is sample one
// - start checked at 8,9,10 or 4,5,6
// - majority high start is noise, rearm
// - resynchronise sample phase on every start bit
// - per-bit state counter indexes each sample
// - two-of-three vote decides every bit
// - vote window starts 8 or 4
// - only first stop bit is received
// - low stop bit sets frame error flag
// - next start right after stop vote (normal)
// - data plus parity five to ten bits
// - error flags stored with their frame
// - disable drops frame and flushes buffer
// - parity checked when check enable set
module uart_rx_recovery (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial line
  input  wire logic        serial_rx_pin
);

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic                  receiver_enable_bit;  // reception on
  logic                  double_speed_select;  // eight samples per bit
  logic                  parity_check_enable;  // compare parity bit
  logic                  parity_odd;           // odd parity when set
  logic [3:0]            char_size;            // data bits, 5..9
  logic [`RX_BAUD_W-1:0] baud_divisor;         // sample tick period - 1

  // ****************************************************************
  // receiver datapath
  // ****************************************************************
  uart_rx_pkg::rx_state_e state;      // sequencer
  logic                  rx_line;     // synchronised line
  logic [`RX_BAUD_W-1:0] baud_cnt;    // tick divider
  logic                  tick;        // one sample instant
  logic [4:0]            samp_cnt;    // per-bit state, 1..spb
  logic [3:0]            bit_idx;     // bit within frame
  logic [1:0]            votes;       // first two centre samples
  logic                  line_high;   // idle level seen, edge armed
  logic [9:0]            frame_bits;  // data then parity
  logic                  frame_done;  // one-cycle completion pulse
  uart_rx_pkg::rx_entry_s done_entry; // frame handed to buffer
  logic                  ovr_pend;    // loss waiting for next frame

  // ****************************************************************
  // receive buffer, two entries
  // ****************************************************************
  uart_rx_pkg::rx_entry_s buf_mem [2];
  logic                  wr_ptr;      // next slot written
  logic                  rd_ptr;      // slot shown to software
  logic [1:0]            buf_cnt;     // entries held
  logic                  pop;         // data register read

  // ****************************************************************
  // mode-dependent figures
  // ****************************************************************
  logic [4:0] spb;       // samples per bit
  logic [4:0] vote_lo;   // first voting sample
  logic [4:0] snum;      // number of the sample now taken
  logic [3:0] csz;       // legal character size
  logic [3:0] last_idx;  // index of last data or parity bit
  logic       vote;      // majority of the three centre samples
  logic       calc_par;  // parity computed over data bits

  // sample rate and voting window follow the speed select
  always_comb begin
    spb     = double_speed_select ? `RX_SPB_DOUBLE
                                  : `RX_SPB_NORMAL;
    vote_lo = double_speed_select ? `RX_VOTE_DOUBLE
                                  : `RX_VOTE_NORMAL;
    snum    = (samp_cnt == spb) ? 5'h01 : samp_cnt + 5'h01;
    // out-of-range sizes fall back to eight bits
    if (char_size < `RX_CSZ_MIN || char_size > `RX_CSZ_MAX) begin
      csz = `RX_CSZ_DEFAULT;
    end else begin
      csz = char_size;
    end
    last_idx = csz - 4'h1 + {3'h0, parity_check_enable};
    vote = (votes[0] & votes[1]) | (votes[0] & rx_line)
         | (votes[1] & rx_line);
  end

  // parity of the data bits only, odd setting inverts
  always_comb begin
    calc_par = parity_odd;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(csz)) begin
        calc_par = calc_par ^ frame_bits[i];
      end
    end
  end

  // ****************************************************************
  // line conditioning and sample tick
  // ****************************************************************
  rx_line_sync u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (serial_rx_pin),
    .level_out (rx_line)
  );

  // divider reloads from the divisor; held while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn || !receiver_enable_bit) begin
      baud_cnt <= `RX_BAUD_RESET;
      tick     <= 1'b0;
    end else if (baud_cnt == 0) begin
      baud_cnt <= baud_divisor;
      tick     <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt - 1'b1;
      tick     <= 1'b0;
    end
  end

  // ****************************************************************
  // clock and data recovery sequencer
  // ****************************************************************
  // disable kills a frame mid-flight; nothing of it survives
  always_ff @(posedge aclk) begin
    frame_done <= 1'b0;
    if (!aresetn || !receiver_enable_bit) begin
      state      <= uart_rx_pkg::st_idle;
      samp_cnt   <= 5'h00;
      bit_idx    <= 4'h0;
      votes      <= 2'b00;
      line_high  <= 1'b0;
      frame_bits <= 10'h000;
      done_entry <= '0;
    end else if (tick) begin
      unique case (state)
        uart_rx_pkg::st_idle: begin
          line_high <= rx_line;
          // first low after a high sample starts the count
          if (line_high && !rx_line) begin
            state    <= uart_rx_pkg::st_start;
            samp_cnt <= 5'h01;
          end
        end
        uart_rx_pkg::st_start: begin
          samp_cnt <= snum;
          if (snum == vote_lo) begin
            votes[0] <= rx_line;
          end
          if (snum == vote_lo + 5'h01) begin
            votes[1] <= rx_line;
          end
          if (snum == vote_lo + 5'h02 && vote) begin
            // spike rejected; wait for the line to rise again
            state     <= uart_rx_pkg::st_idle;
            line_high <= 1'b0;
            samp_cnt  <= 5'h00;
          end else if (snum == spb) begin
            state   <= uart_rx_pkg::st_bits;
            bit_idx <= 4'h0;
          end
        end
        uart_rx_pkg::st_bits: begin
          samp_cnt <= snum;
          if (snum == vote_lo) begin
            votes[0] <= rx_line;
          end
          if (snum == vote_lo + 5'h01) begin
            votes[1] <= rx_line;
          end
          if (snum == vote_lo + 5'h02) begin
            frame_bits[bit_idx] <= vote;
          end
          if (snum == spb) begin
            if (bit_idx == last_idx) begin
              state <= uart_rx_pkg::st_stop;
            end else begin
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
        uart_rx_pkg::st_stop: begin
          samp_cnt <= snum;
          if (snum == vote_lo) begin
            votes[0] <= rx_line;
          end
          if (snum == vote_lo + 5'h01) begin
            votes[1] <= rx_line;
          end
          if (snum == vote_lo + 5'h02) begin
            // further stop bits are simply idle line
            frame_done            <= 1'b1;
            done_entry.frame_err  <= ~vote;
            done_entry.parity_err <= parity_check_enable
                                   & (calc_par != frame_bits[csz]);
            done_entry.data       <= frame_bits[8:0]
                                   & ~(9'h1FF << csz);
            done_entry.overrun    <= 1'b0;
            // a low stop bit needs a high line before rearming
            line_high <= vote;
            if (double_speed_select) begin
              state <= uart_rx_pkg::st_tail;
            end else begin
              state    <= uart_rx_pkg::st_idle;
              samp_cnt <= 5'h00;
            end
          end
        end
        uart_rx_pkg::st_tail: begin
          // coarser sampling: first low counted one sample later
          state     <= uart_rx_pkg::st_idle;
          samp_cnt  <= 5'h00;
          line_high <= line_high & rx_line;
        end
      endcase
    end
  end

  // ****************************************************************
  // receive buffer with per-frame status
  // ****************************************************************
  logic do_push;  // completed frame finds room
  assign do_push = frame_done && (buf_cnt != 2'h2 || pop);

  // flushed on disable; overrun rides with the next stored frame
  always_ff @(posedge aclk) begin
    if (!aresetn || !receiver_enable_bit) begin
      wr_ptr   <= 1'b0;
      rd_ptr   <= 1'b0;
      buf_cnt  <= 2'h0;
      ovr_pend <= 1'b0;
    end else begin
      if (do_push) begin
        buf_mem[wr_ptr]         <= done_entry;
        buf_mem[wr_ptr].overrun <= ovr_pend;
        wr_ptr                  <= ~wr_ptr;
        ovr_pend                <= 1'b0;
      end else if (frame_done) begin
        ovr_pend <= 1'b1;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      buf_cnt <= buf_cnt + {1'b0, do_push} - {1'b0, pop};
    end
  end

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  logic wr_go;  // both halves present, slave free
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
              && !s_axi_bvalid;

  // address and data taken together, response the cycle after
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_RESP_OKAY;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        // status and data are read-only; writes there are refused
        s_axi_bresp  <= (s_axi_awaddr == `RX_CTRL_OFS
                      || s_axi_awaddr == `RX_BAUD_OFS)
                      ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // a literal cannot be bit-selected, so name the reset word
  localparam logic [31:0] ctrl_rst = `RX_CTRL_RESET;

  // register update on the accepting cycle, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receiver_enable_bit <= ctrl_rst[`RX_CTRL_EN_BIT];
      double_speed_select <= ctrl_rst[`RX_CTRL_DS_BIT];
      parity_check_enable <= ctrl_rst[`RX_CTRL_PEN_BIT];
      parity_odd          <= ctrl_rst[`RX_CTRL_PODD_BIT];
      char_size <= ctrl_rst[`RX_CTRL_CSZ_MSB:`RX_CTRL_CSZ_LSB];
      baud_divisor        <= `RX_BAUD_RESET;
    end else if (s_axi_awready) begin
      if (s_axi_awaddr == `RX_CTRL_OFS && s_axi_wstrb[0]) begin
        receiver_enable_bit <= s_axi_wdata[`RX_CTRL_EN_BIT];
        double_speed_select <= s_axi_wdata[`RX_CTRL_DS_BIT];
        parity_check_enable <= s_axi_wdata[`RX_CTRL_PEN_BIT];
        parity_odd          <= s_axi_wdata[`RX_CTRL_PODD_BIT];
        char_size <= s_axi_wdata[`RX_CTRL_CSZ_MSB:`RX_CTRL_CSZ_LSB];
      end
      if (s_axi_awaddr == `RX_BAUD_OFS) begin
        if (s_axi_wstrb[0]) begin
          baud_divisor[7:0] <= s_axi_wdata[7:0];
        end
        if (s_axi_wstrb[1]) begin
          baud_divisor[`RX_BAUD_W-1:8] <= s_axi_wdata[`RX_BAUD_W-1:8];
        end
      end
    end
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  uart_rx_pkg::rx_entry_s head;  // oldest unread frame
  assign head = buf_mem[rd_ptr];
  assign pop  = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
             && s_axi_araddr == `RX_DATA_OFS && buf_cnt != 2'h0;

  // read taken one cycle after arvalid, data the cycle after that
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AXI_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `AXI_RESP_OKAY;
        unique case (s_axi_araddr)
          `RX_CTRL_OFS: begin
            s_axi_rdata[`RX_CTRL_EN_BIT]   <= receiver_enable_bit;
            s_axi_rdata[`RX_CTRL_DS_BIT]   <= double_speed_select;
            s_axi_rdata[`RX_CTRL_PEN_BIT]  <= parity_check_enable;
            s_axi_rdata[`RX_CTRL_PODD_BIT] <= parity_odd;
            s_axi_rdata[`RX_CTRL_CSZ_MSB:`RX_CTRL_CSZ_LSB] <= char_size;
          end
          `RX_BAUD_OFS: begin
            s_axi_rdata[`RX_BAUD_W-1:0] <= baud_divisor;
          end
          `RX_STATUS_OFS: begin
            // error flags describe the oldest unread frame; busy shows the sequencer out of idle
            s_axi_rdata[`RX_STAT_RXC_BIT]  <= buf_cnt != 2'h0;
            s_axi_rdata[`RX_STAT_FE_BIT]   <= (buf_cnt != 2'h0)
                                            & head.frame_err;
            s_axi_rdata[`RX_STAT_DOR_BIT]  <= (buf_cnt != 2'h0)
                                            & head.overrun;
            s_axi_rdata[`RX_STAT_PE_BIT]   <= (buf_cnt != 2'h0)
                                            & head.parity_err;
            s_axi_rdata[`RX_STAT_BUSY_BIT] <=
              state != uart_rx_pkg::st_idle;
          end
          `RX_DATA_OFS: begin
            // empty buffer reads zero and pops nothing
            if (buf_cnt != 2'h0) begin
              s_axi_rdata[8:0] <= head.data;
            end
          end
          default: begin
            s_axi_rresp <= `AXI_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : uart_rx_recovery

// ### verif/uart_tx_model.sv
`timescale 1ns/1ps

// ****************************************************************
// remote serial transmitter on the receive line
// ****************************************************************
module uart_tx_model (
  // clock
  input  wire logic aclk,
  // serial line
  output logic      line
);
  // idle high between frames
  initial line = 1'b1;

  // lsb first, exact bit time, so no rate error
  task automatic send(input logic [15:0] f, input int n, input int cpb);
    for (int i = 0; i < n; i++) begin  // start, payload, stop
      @(posedge aclk);
      line <= f[i];
      repeat (cpb - 1) @(posedge aclk);
    end
    @(posedge aclk);
    line <= 1'b1;  // idle again, also after a low stop
  endtask : send

  // low pulse shorter than the start vote point
  task automatic glitch(input int len);
    @(posedge aclk);
    line <= 1'b0;
    repeat (len) @(posedge aclk);
    line <= 1'b1;
  endtask : glitch
endmodule : uart_tx_model

// ### verif/uart_rx_recovery_sva.sv
`timescale 1ns/1ps

// ****************************************************************
// register bus timing at the block's ports
// ****************************************************************
module uart_rx_recovery_sva (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // serial line
  input wire logic        serial_rx_pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both write channels taken together, answer one cycle later
  property p_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
      |=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("write not taken");
  property p_aw_pulse;
    s_axi_awready |=> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("ready too long");
  // a response only ever follows an accepted write
  property p_b_cause;
    $rose(s_axi_bvalid) |-> $past(s_axi_awready);
  endproperty
  a_b_cause: assert property (p_b_cause) else $error("stray bvalid");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp moved");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("bvalid stuck");
  // read taken next cycle, data the cycle after
  property p_rd_take;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
      |=> s_axi_arready ##1 (s_axi_rvalid && !s_axi_arready);
  endproperty
  a_rd_take: assert property (p_rd_take) else $error("read not taken");
  // status and data must not shift under a stalled reader
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rdata moved");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("rvalid stuck");

  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  c_r_stall: cover property (s_axi_rvalid && !s_axi_rready);
  c_start: cover property ($fell(serial_rx_pin));
endmodule : uart_rx_recovery_sva

// ### verif/tb_uart_rx_recovery.sv
`timescale 1ns/1ps
`include "uart_rx_cfg.svh"

// ********
// bench: register accesses around serial frames
// ********
module tb_uart_rx_recovery;
  localparam int DIV   = 1;               // tick every two clocks
  localparam int CPB_N = (DIV + 1) * 16;  // clocks per bit, normal
  localparam int CPB_D = (DIV + 1) * 8;   // clocks per bit, double
  logic        aclk     = 1'b0;           // 40 MHz
  logic        aresetn  = 1'b0;           // sync, active low
  logic [11:0] aw_addr  = 12'h000;        // write channels
  logic        aw_valid = 1'b0;
  logic        aw_ready;
  logic [31:0] w_data   = 32'h0000_0000;
  logic [3:0]  w_strb   = 4'hf;
  logic        w_valid  = 1'b0;
  logic        w_ready;
  logic [1:0]  b_resp;
  logic        b_valid;
  logic        b_ready  = 1'b0;
  logic [11:0] ar_addr  = 12'h000;        // read channels
  logic        ar_valid = 1'b0;
  logic        ar_ready;
  logic [31:0] r_data;
  logic [1:0]  r_resp;
  logic        r_valid;
  logic        r_ready  = 1'b0;
  logic        rx_line;                   // serial line
  int          bad_count   = 0;           // mismatches
  int          comparisons = 0;           // checks made

  always #12.5 aclk = ~aclk;

  uart_rx_recovery DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
    .s_axi_awready(aw_ready), .s_axi_wdata(w_data), .s_axi_wstrb(w_strb),
    .s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
    .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
    .s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
    .s_axi_rvalid(r_valid), .s_axi_rready(r_ready),
    .serial_rx_pin(rx_line));
  uart_tx_model TX (.aclk(aclk), .line(rx_line));

  // ********
  // verdict, compare and bounded wait
  // ********
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    comparisons++;
    if (g !== e) begin  // case compare, unknown never matches
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic guard(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200) begin  // handshake hung
      bad_count++;
      stop_test();
    end
  endtask : guard

  // ********
  // bus master: ready raised late to stall the response
  // ********
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    aw_addr  <= a;
    w_data   <= d;
    aw_valid <= 1'b1;
    w_valid  <= 1'b1;
    do guard(n); while (aw_ready !== 1'b1);
    aw_valid <= 1'b0;
    w_valid  <= 1'b0;
    do guard(n); while (b_valid !== 1'b1);
    b_ready <= 1'b1;
    check("bresp", 32'(er), 32'(b_resp));
    guard(n);
    b_ready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er, input string what);
    int n;
    n = 0;
    ar_addr  <= a;
    ar_valid <= 1'b1;
    do guard(n); while (ar_ready !== 1'b1);
    ar_valid <= 1'b0;
    do guard(n); while (r_valid !== 1'b1);
    r_ready <= 1'b1;
    check("rresp", 32'(er), 32'(r_resp));
    check(what, ed, r_data);
    guard(n);
    r_ready <= 1'b0;
  endtask : rd

  // start low, payload lsb first, one stop bit
  function automatic logic [15:0] frm(input logic [9:0] p, input int n,
                                      input logic s);
    logic [15:0] f;
    f = {5'h00, p, 1'b0};
    f[n + 1] = s;
    return f;
  endfunction : frm

  // configure, send one frame, read status then data
  task automatic rx(input logic [31:0] c, input logic [9:0] p,
                    input int n, input logic s, input logic [31:0] es,
                    input logic [31:0] ed);
    wr(`RX_CTRL_OFS, c, 2'b00);
    TX.send(frm(p, n, s), n + 2, CPB_N);
    repeat (CPB_N) @(posedge aclk);
    rd(`RX_STATUS_OFS, es, 2'b00, "status");
    rd(`RX_DATA_OFS, ed, 2'b00, "data");
  endtask : rx

  // ********
  // main sequence
  // ********
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`RX_CTRL_OFS, `RX_CTRL_RESET, 2'b00, "ctrl");
    rd(`RX_STATUS_OFS, 32'h0000_0000, 2'b00, "status");
    rd(12'h010, 32'h0000_0000, 2'b10, "unmapped");
    wr(`RX_STATUS_OFS, 32'h0000_0001, 2'b10);
    wr(`RX_BAUD_OFS, 32'(DIV), 2'b00);
    rd(`RX_BAUD_OFS, 32'(DIV), 2'b00, "baud");
    rx(32'h0000_0081, 10'h0a5, 8, 1'b1, 32'h0000_0001, 32'h0000_00a5);
    rx(32'h0000_0081, 10'h03c, 8, 1'b0, 32'h0000_0003, 32'h0000_003c);
    rx(32'h0000_0095, 10'h1a5, 10, 1'b1, 32'h0000_0009, 32'h0000_01a5);
    rx(32'h0000_0055, 10'h033, 6, 1'b1, 32'h0000_0001, 32'h0000_0013);
    // double speed, two frames back to back, both kept
    wr(`RX_CTRL_OFS, 32'h0000_0083, 2'b00);
    TX.send(frm(10'h05a, 8, 1'b1), 10, CPB_D);
    TX.send(frm(10'h0c3, 8, 1'b1), 10, CPB_D);
    repeat (CPB_N) @(posedge aclk);
    rd(`RX_STATUS_OFS, 32'h0000_0001, 2'b00, "status");
    rd(`RX_DATA_OFS, 32'h0000_005a, 2'b00, "data");
    rd(`RX_STATUS_OFS, 32'h0000_0001, 2'b00, "status");
    rd(`RX_DATA_OFS, 32'h0000_00c3, 2'b00, "data");
    // short low pulse must be dropped as noise
    wr(`RX_CTRL_OFS, 32'h0000_0081, 2'b00);
    TX.glitch(12);
    repeat (CPB_N) @(posedge aclk);
    rd(`RX_STATUS_OFS, 32'h0000_0000, 2'b00, "status");
    // stored frame lost when the receiver is switched off
    TX.send(frm(10'h077, 8, 1'b1), 10, CPB_N);
    rd(`RX_STATUS_OFS, 32'h0000_0001, 2'b00, "status");
    wr(`RX_CTRL_OFS, 32'h0000_0080, 2'b00);
    rd(`RX_STATUS_OFS, 32'h0000_0000, 2'b00, "status");
    stop_test();
  end
endmodule : tb_uart_rx_recovery

bind uart_rx_recovery uart_rx_recovery_sva SVA (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .serial_rx_pin);
